/* src/cwd_config_word_decoder.sv */
module cwd_config_word_decoder (
	input  wire logic          clk_i,            // Clock
	input  wire logic          rst_b_i,          // Sync reset, active low
	input  cwd_pkg::cwd_cfg_type cfg_i,          // Configuration fields
	input  wire logic          cfg_wr_i,         // Config field update strobe
	input  wire logic          boot_wr_req_i,    // Write to boot segment
	input  wire logic          gen_wr_req_i,     // Write to general segment
	input  wire logic          src_ready_i,      // Selected source is ready
	input  wire logic          osc_fail_i,       // Oscillator failure seen
	output cwd_pkg::cwd_prot_type prot_o,        // Decoded protection
	output logic               boot_wr_ok_o,     // Boot write allowed
	output logic               gen_wr_ok_o,      // General write allowed
	output logic [2:0]         sys_clk_sel_o,    // Active clock source
	output logic               on_fast_rc_o,     // Running on start RC
	output logic               switch_en_o,      // Clock switching enabled
	output logic               monitor_en_o,     // Fail-safe monitor on
	output logic               clk_fail_trap_o,  // Clock failure trap
	output logic               pin_clk_out_o,    // Second pin drives clock
	output logic               pin_gpio_o,       // Second pin is GPIO
	output logic               posc_en_o,        // Primary oscillator on
	output logic [1:0]         posc_mode_o       // Primary oscillator mode
);
	typedef enum logic [1:0] {
		CWD_BOOT,
		CWD_TWO_SPEED,
		CWD_RUN,
		CWD_FAILED
	} cwd_state_type;

	cwd_pkg::cwd_cfg_type  cfg;
	cwd_pkg::cwd_prot_type next_prot;
	cwd_state_type         state;
	logic [2:0]            clk_sel_held;
	logic                  next_switch_en;
	logic                  next_monitor_en;
	logic                  crystal_mode;

	cwd_prot_decode i_cwd_prot_decode (
		.cfg_i  (cfg),
		.prot_o (next_prot)
	);

	// Fields survive reset like the nonvolatile words they mirror, so a
	// deferred select and the start-up mode reach the next reset exit
	// Limitation: a load must come while reset is still held at power-up
	always_ff @(posedge clk_i) begin
		if (cfg_wr_i)
			cfg <= cfg_i;
	end

	// Select captured at reset exit, updated live only without switching
	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			clk_sel_held <= cwd_pkg::RST_CLK;
		else if (state == CWD_BOOT || !switch_en_o)
			clk_sel_held <= cfg.initial_clock_select;
	end

	// Switch mode fields decoded as two separate enables
	always_comb begin
		next_switch_en = (cfg.switch_monitor_mode == cwd_pkg::SWM_SWITCH_ONLY)
			|| (cfg.switch_monitor_mode == cwd_pkg::SWM_BOTH);
		next_monitor_en =
			(cfg.switch_monitor_mode == cwd_pkg::SWM_BOTH);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			switch_en_o  <= 1'b0;
			monitor_en_o <= 1'b0;
		end else begin
			switch_en_o  <= next_switch_en;
			monitor_en_o <= next_monitor_en;
		end
	end

	// Start-up sequencing and fail-safe fallback
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state <= CWD_BOOT;
		end else begin
			case (state)
				CWD_BOOT:
					state <= cfg.two_speed_startup_en ?
						CWD_TWO_SPEED : CWD_RUN;
				CWD_TWO_SPEED:
					if (src_ready_i)
						state <= CWD_RUN;
				CWD_RUN:
					if (monitor_en_o && osc_fail_i)
						state <= CWD_FAILED;
				CWD_FAILED:
					state <= CWD_FAILED; // Left only by reset
				default:
					state <= CWD_BOOT;
			endcase
		end
	end

	// Active source; fast RC during two-speed start and after a failure
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			sys_clk_sel_o <= cwd_pkg::RST_CLK;
			on_fast_rc_o  <= 1'b1;
		end else if (state == CWD_TWO_SPEED || state == CWD_FAILED) begin
			sys_clk_sel_o <= cwd_pkg::CLK_FRC;
			on_fast_rc_o  <= 1'b1;
		end else if (state == CWD_RUN) begin
			sys_clk_sel_o <= clk_sel_held;
			on_fast_rc_o  <= 1'b0;
		end
	end

	// Trap is sticky until reset so software sees it
	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			clk_fail_trap_o <= 1'b0;
		else if (state == CWD_RUN && monitor_en_o && osc_fail_i)
			clk_fail_trap_o <= 1'b1;
	end

	// Primary oscillator and second pin
	assign crystal_mode = (cfg.primary_osc_mode == cwd_pkg::POSC_HS) ||
		(cfg.primary_osc_mode == cwd_pkg::POSC_XT);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			posc_en_o     <= 1'b0;
			posc_mode_o   <= cwd_pkg::POSC_OFF;
			pin_clk_out_o <= 1'b0;
			pin_gpio_o    <= 1'b0;
		end else begin
			posc_en_o   <= cfg.primary_osc_mode != cwd_pkg::POSC_OFF;
			posc_mode_o <= cfg.primary_osc_mode;
			// Crystal owns the pin, neither function applies
			pin_clk_out_o <= !crystal_mode && cfg.second_pin_function;
			pin_gpio_o    <= !crystal_mode && !cfg.second_pin_function;
		end
	end

	// Protection outputs and write guards
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			prot_o       <= '0;
			boot_wr_ok_o <= 1'b0;
			gen_wr_ok_o  <= 1'b0;
		end else begin
			prot_o       <= next_prot;
			boot_wr_ok_o <= boot_wr_req_i && next_prot.boot_present &&
				next_prot.boot_writable;
			gen_wr_ok_o  <= gen_wr_req_i && next_prot.general_writable;
		end
	end

	// Checks
	property p_trap;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == CWD_RUN && monitor_en_o && osc_fail_i) |=>
			clk_fail_trap_o ##1 (sys_clk_sel_o == cwd_pkg::CLK_FRC);
	endproperty
	a_trap: assert property (p_trap) else $error("no trap on failure");

	property p_boot_wp;
		@(posedge clk_i) disable iff (!rst_b_i)
		(!cfg.boot_write_protect_n) |=> !boot_wr_ok_o;
	endproperty
	a_boot_wp: assert property (p_boot_wp) else $error("boot write leak");

	property p_gen_wp;
		@(posedge clk_i) disable iff (!rst_b_i)
		(gen_wr_req_i && cfg.general_write_protect_n) |=> gen_wr_ok_o;
	endproperty
	a_gen_wp: assert property (p_gen_wp) else $error("general write lost");

	property p_mon_implies_sw;
		@(posedge clk_i) disable iff (!rst_b_i)
		monitor_en_o |-> switch_en_o;
	endproperty
	a_mon_implies_sw: assert property (p_mon_implies_sw)
		else $error("monitor without switching");

	property p_sw_only;
		@(posedge clk_i) disable iff (!rst_b_i)
		(cfg.switch_monitor_mode == cwd_pkg::SWM_SWITCH_ONLY) |=>
			(switch_en_o && !monitor_en_o);
	endproperty
	a_sw_only: assert property (p_sw_only) else $error("bad 01 decode");

	property p_two_speed;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == CWD_TWO_SPEED) |=> on_fast_rc_o;
	endproperty
	a_two_speed: assert property (p_two_speed) else $error("not on RC");

	property p_pin;
		@(posedge clk_i) disable iff (!rst_b_i)
		!(pin_clk_out_o && pin_gpio_o);
	endproperty
	a_pin: assert property (p_pin) else $error("pin both functions");

	property p_posc;
		@(posedge clk_i) disable iff (!rst_b_i)
		(cfg.primary_osc_mode == cwd_pkg::POSC_OFF) |=> !posc_en_o;
	endproperty
	a_posc: assert property (p_posc) else $error("primary not off");

	property p_hold_sel;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == CWD_RUN && switch_en_o) |=> $stable(clk_sel_held);
	endproperty
	a_hold_sel: assert property (p_hold_sel) else $error("select moved");
endmodule

/* src/cwd_pkg.sv */
package cwd_pkg;
	// Configuration field encodings
	localparam logic [2:0] BOOT_SIZE_MID_STD  = 3'h6;
	localparam logic [2:0] BOOT_SIZE_MID_HIGH = 3'h2;
	localparam logic [2:0] BOOT_SIZE_BIG_STD  = 3'h5;
	localparam logic [2:0] BOOT_SIZE_BIG_HIGH = 3'h1;
	localparam logic [2:0] BOOT_SIZE_MAX_STD  = 3'h4;
	localparam logic [2:0] BOOT_SIZE_MAX_HIGH = 3'h0;
	localparam logic [23:0] BOOT_END_MID = 24'h0003fe;
	localparam logic [23:0] BOOT_END_BIG = 24'h0007fe;
	localparam logic [23:0] BOOT_END_MAX = 24'h000ffe;
	localparam logic [11:0] BOOT_WORDS_MID = 12'h300;
	localparam logic [11:0] BOOT_WORDS_BIG = 12'h700;
	localparam logic [1:0] GEN_CP_NONE = 2'h3;
	localparam logic [1:0] GEN_CP_STD  = 2'h2;
	localparam logic [2:0] CLK_FRC_POST = 3'h7;
	localparam logic [2:0] CLK_FRC_DIV16 = 3'h6;
	localparam logic [2:0] CLK_LOW_POWER_INTERNAL_RC     = 3'h5;
	localparam logic [2:0] CLK_SECOND   = 3'h4;
	localparam logic [2:0] CLK_PRI_PLL  = 3'h3;
	localparam logic [2:0] CLK_PRI      = 3'h2;
	localparam logic [2:0] CLK_FRC_PLL  = 3'h1;
	localparam logic [2:0] CLK_FRC      = 3'h0;
	localparam logic [1:0] SWM_SWITCH_ONLY = 2'h1;
	localparam logic [1:0] SWM_BOTH        = 2'h0;
	localparam logic [1:0] POSC_OFF = 2'h3;
	localparam logic [1:0] POSC_HS  = 2'h2;
	localparam logic [1:0] POSC_XT  = 2'h1;
	localparam logic [1:0] POSC_EC  = 2'h0;
	// Reset values of decoded outputs
	localparam logic [2:0] RST_CLK = 3'h0;

	typedef enum logic [1:0] {
		SEC_NONE,
		SEC_STD,
		SEC_HIGH
	} cwd_sec_type;

	// Raw configuration fields
	typedef struct packed {
		logic       boot_write_protect_n;
		logic [2:0] boot_size_security;
		logic [1:0] general_code_protect;
		logic       general_write_protect_n;
		logic       two_speed_startup_en;
		logic [2:0] initial_clock_select;
		logic [1:0] switch_monitor_mode;
		logic       second_pin_function;
		logic [1:0] primary_osc_mode;
	} cwd_cfg_type;

	// Decoded protection
	typedef struct packed {
		logic        boot_present;
		cwd_sec_type boot_security;
		logic [23:0] boot_end;
		logic [11:0] boot_words;
		logic        boot_writable;
		cwd_sec_type general_security;
		logic        general_writable;
	} cwd_prot_type;
endpackage

/* src/cwd_prot_decode.sv */
// Pure decode of the memory-protection fields
module cwd_prot_decode (
	input  cwd_pkg::cwd_cfg_type  cfg_i,  // Latched configuration
	output cwd_pkg::cwd_prot_type prot_o  // Decoded protection
);
	// Boot size/security table, unlisted codes fall to no segment
	always_comb begin
		prot_o = '0;
		prot_o.boot_writable = cfg_i.boot_write_protect_n;
		prot_o.general_writable = cfg_i.general_write_protect_n;
		case (cfg_i.boot_size_security)
			cwd_pkg::BOOT_SIZE_MID_STD, cwd_pkg::BOOT_SIZE_MID_HIGH: begin
				prot_o.boot_present = 1'b1;
				prot_o.boot_end = cwd_pkg::BOOT_END_MID;
				prot_o.boot_words = cwd_pkg::BOOT_WORDS_MID;
			end
			cwd_pkg::BOOT_SIZE_BIG_STD, cwd_pkg::BOOT_SIZE_BIG_HIGH: begin
				prot_o.boot_present = 1'b1;
				prot_o.boot_end = cwd_pkg::BOOT_END_BIG;
				prot_o.boot_words = cwd_pkg::BOOT_WORDS_BIG;
			end
			cwd_pkg::BOOT_SIZE_MAX_STD, cwd_pkg::BOOT_SIZE_MAX_HIGH: begin
				prot_o.boot_present = 1'b1;
				prot_o.boot_end = cwd_pkg::BOOT_END_MAX;
			end
			default: begin
				prot_o.boot_present = 1'b0;
			end
		endcase
		// Bit 2 clear means high security
		if (prot_o.boot_present)
			prot_o.boot_security = cfg_i.boot_size_security[2] ?
				cwd_pkg::SEC_STD : cwd_pkg::SEC_HIGH;
		else
			prot_o.boot_security = cwd_pkg::SEC_NONE;
		// Codes below 10 treated as standard too
		if (cfg_i.general_code_protect == cwd_pkg::GEN_CP_NONE)
			prot_o.general_security = cwd_pkg::SEC_NONE;
		else
			prot_o.general_security = cwd_pkg::SEC_STD;
	end
endmodule

/* verif/test_config_word_decoder.sv */
module test_config_word_decoder;
	timeunit 1ns;
	timeprecision 100ps;

	// One table row: raw fields beside the decode they must give
	// Security codes: 0 none, 1 standard, 2 high
	typedef struct packed {
		cwd_pkg::cwd_cfg_type cfg;
		logic                 pres;
		logic [1:0]           bsec;
		logic [23:0]          bend;
		logic [11:0]          words;
		logic [1:0]           gsec;
		logic                 clkout;
		logic                 gpio;
	} cwd_row_type;

	logic                  clk_i;
	logic                  rst_b_i;
	cwd_pkg::cwd_cfg_type  cfg_i;
	logic                  cfg_wr_i;
	logic                  boot_wr_req_i;
	logic                  gen_wr_req_i;
	logic                  src_ready_i;
	logic                  osc_fail_i;
	cwd_pkg::cwd_prot_type prot_o;
	logic                  boot_wr_ok_o;
	logic                  gen_wr_ok_o;
	logic [2:0]            sys_clk_sel_o;
	logic                  on_fast_rc_o;
	logic                  switch_en_o;
	logic                  monitor_en_o;
	logic                  clk_fail_trap_o;
	logic                  pin_clk_out_o;
	logic                  pin_gpio_o;
	logic                  posc_en_o;
	logic [1:0]            posc_mode_o;
	int                    error_cnt;
	int                    compares;
	int                    cycles;
	cwd_row_type           rows [8];

	cwd_config_word_decoder i_cwd_config_word_decoder (
		.clk_i           (clk_i),
		.rst_b_i         (rst_b_i),
		.cfg_i           (cfg_i),
		.cfg_wr_i        (cfg_wr_i),
		.boot_wr_req_i   (boot_wr_req_i),
		.gen_wr_req_i    (gen_wr_req_i),
		.src_ready_i     (src_ready_i),
		.osc_fail_i      (osc_fail_i),
		.prot_o          (prot_o),
		.boot_wr_ok_o    (boot_wr_ok_o),
		.gen_wr_ok_o     (gen_wr_ok_o),
		.sys_clk_sel_o   (sys_clk_sel_o),
		.on_fast_rc_o    (on_fast_rc_o),
		.switch_en_o     (switch_en_o),
		.monitor_en_o    (monitor_en_o),
		.clk_fail_trap_o (clk_fail_trap_o),
		.pin_clk_out_o   (pin_clk_out_o),
		.pin_gpio_o      (pin_gpio_o),
		.posc_en_o       (posc_en_o),
		.posc_mode_o     (posc_mode_o)
	);

	// 40 MHz clock
	initial begin
		clk_i = 1'h0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Hang guard; the whole run needs under a hundred cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("compares %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Inputs move 1 ns after the edge, clear of sampling
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Latch at first edge, output flops at second, held select reaches sys_clk_sel_o at third
	task automatic load(input cwd_pkg::cwd_cfg_type c);
		cfg_i = c;
		cfg_wr_i = 1'h1;
		step(1);
		cfg_wr_i = 1'h0;
		step(2);
	endtask

	initial begin
		error_cnt = 0;
		compares = 0;
		cycles = 0;
		rst_b_i = 1'h0;
		// Reset configuration loaded while reset is held
		cfg_i = 16'hff1f;
		cfg_wr_i = 1'h1;
		boot_wr_req_i = 1'h1;
		gen_wr_req_i = 1'h1;
		src_ready_i = 1'h1;
		osc_fail_i = 1'h0;
		rows[0] = '{16'h8e1c, 1'h1, 2'h2, 24'h000ffe, 12'h000, 2'h0, 1'h1, 1'h0};
		rows[1] = '{16'h1831, 1'h1, 2'h2, 24'h0007fe, 12'h700, 2'h1, 1'h0, 1'h0};
		rows[2] = '{16'hae5e, 1'h1, 2'h2, 24'h0003fe, 12'h300, 2'h0, 1'h0, 1'h0};
		rows[3] = '{16'hb873, 1'h0, 2'h0, 24'h000000, 12'h000, 2'h1, 1'h0, 1'h1};
		rows[4] = '{16'hce9f, 1'h1, 2'h1, 24'h000ffe, 12'h000, 2'h0, 1'h1, 1'h0};
		rows[5] = '{16'h5ab0, 1'h1, 2'h1, 24'h0007fe, 12'h700, 2'h1, 1'h0, 1'h1};
		rows[6] = '{16'hecdd, 1'h1, 2'h1, 24'h0003fe, 12'h300, 2'h0, 1'h0, 1'h0};
		rows[7] = '{16'hfaf2, 1'h0, 2'h0, 24'h000000, 12'h000, 2'h1, 1'h0, 1'h0};
		// Values held in reset, then the reset configuration
		step(12);
		check(on_fast_rc_o, 1'h1);
		check(posc_mode_o, 2'h3);
		check(clk_fail_trap_o, 1'h0);
		cfg_wr_i = 1'h0;
		rst_b_i = 1'h1;
		step(3);
		check(switch_en_o, 1'h0);
		check(prot_o.boot_present, 1'h0);
		check(boot_wr_ok_o, 1'h0);
		check(posc_en_o, 1'h0);
		$display("reset test done");
		// Table rows, switching kept off so selects act at once
		for (int i = 0; i < 8; i++) begin
			load(rows[i].cfg);
			check(prot_o.boot_present, rows[i].pres);
			check(prot_o.boot_security, rows[i].bsec);
			if (rows[i].pres)
				check(prot_o.boot_end, rows[i].bend);
			check(prot_o.boot_words, rows[i].words);
			check(prot_o.general_security, rows[i].gsec);
			check(boot_wr_ok_o, rows[i].pres & rows[i].cfg[15]);
			check(gen_wr_ok_o, rows[i].cfg[9]);
			check(sys_clk_sel_o, rows[i].cfg[7:5]);
			check({switch_en_o, monitor_en_o}, 2'h0);
			check(pin_clk_out_o, rows[i].clkout);
			check(pin_gpio_o, rows[i].gpio);
			check(posc_en_o, rows[i].cfg[1:0] != 2'h3);
			check(posc_mode_o, rows[i].cfg[1:0]);
			$display("row %0d done", i);
		end
		// Switching only: a new select must wait for reset
		load(16'hfaea);
		check({switch_en_o, monitor_en_o}, 2'h2);
		load(16'hfa4a);
		check(sys_clk_sel_o, 3'h7);
		osc_fail_i = 1'h1;
		step(2);
		check(clk_fail_trap_o, 1'h0);
		osc_fail_i = 1'h0;
		$display("switch only test done");
		// Monitor on: failure traps and falls back to fast RC
		load(16'hfae2);
		check({switch_en_o, monitor_en_o}, 2'h3);
		osc_fail_i = 1'h1;
		step(1);
		check(clk_fail_trap_o, 1'h1);
		step(1);
		check(sys_clk_sel_o, 3'h0);
		check(on_fast_rc_o, 1'h1);
		osc_fail_i = 1'h0;
		step(3);
		check(clk_fail_trap_o, 1'h1);
		boot_wr_req_i = 1'h0;
		gen_wr_req_i = 1'h0;
		step(1);
		check({boot_wr_ok_o, gen_wr_ok_o}, 2'h0);
		$display("fail test done");
		// Two-speed start: fast RC until the source reports ready
		// Select 011 loaded with switching on waits for the reset
		load(16'hff6b);
		check(sys_clk_sel_o, 3'h0);
		src_ready_i = 1'h0;
		rst_b_i = 1'h0;
		step(2);
		rst_b_i = 1'h1;
		step(5);
		check(clk_fail_trap_o, 1'h0);
		check(on_fast_rc_o, 1'h1);
		src_ready_i = 1'h1;
		for (int k = 0; k < 10 && on_fast_rc_o !== 1'h0; k++)
			step(1);
		check(on_fast_rc_o, 1'h0);
		check(sys_clk_sel_o, 3'h3);
		$display("two speed test done");
		// Direct start: select 010 deferred, then used right after reset
		load(16'hfe4b);
		check(sys_clk_sel_o, 3'h3);
		rst_b_i = 1'h0;
		step(2);
		rst_b_i = 1'h1;
		step(2);
		check(on_fast_rc_o, 1'h0);
		check(sys_clk_sel_o, 3'h2);
		$display("direct start test done");
		tally_and_finish();
	end
endmodule
